// [rtl/bit_sync.sv]
// Two-stage synchroniser for a level arriving from another clock domain.
module bit_sync (
	// Clock and control.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Level in and out.
	input wire logic din,
	output logic dout
);
	logic meta_q;
	logic meta_d;
	logic dout_d;

	// First stage feeds only the second stage.
	always_comb begin
		meta_d = ce ? din : meta_q;
		dout_d = ce ? meta_q : dout;
	end

	// Both stages clear on reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_q <= meta_d;
			dout <= dout_d;
		end
	end
endmodule

// [rtl/lane_monitor.sv]
// Per-lane word lock, lane marker tracking and sync header error counting.
module lane_monitor import rx_check_pkg::*; (
	// Clock and control.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Received blocks of this lane.
	input wire logic blkValid,
	input wire logic hdrBad,
	input wire logic [63:0] blk,
	// Configuration.
	input wire logic [63:0] lanePattern,
	input wire logic [15:0] spacing,
	// Status.
	output logic synced_q,
	output logic syncedErr_q,
	output logic [3:0] errCnt_q,
	output logic errValid_q
);
	typedef enum logic {HUNT, LOCKED} lock_e;
	lock_e st_q, st_d;
	logic [6:0] good_q, good_d;
	logic [4:0] bad_q, bad_d;
	logic [5:0] win_q, win_d;
	logic [15:0] words_q, words_d;
	logic seen_q, seen_d, lost_q, lost_d, miss_q, miss_d;
	logic [2:0] grp_q, grp_d;
	logic [3:0] acc_q, acc_d, errCnt_d;
	logic errValid_d, synced_d, syncedErr_d, isMarker;

	// Lock hunt, marker tracking and error grouping.
	always_comb begin
		st_d = st_q;
		good_d = good_q;
		bad_d = bad_q;
		win_d = win_q;
		words_d = words_q;
		seen_d = seen_q;
		lost_d = lost_q;
		miss_d = miss_q;
		grp_d = grp_q;
		acc_d = acc_q;
		errCnt_d = errCnt_q;
		errValid_d = 1'b0;
		isMarker = !hdrBad && (blk == lanePattern);
		if (blkValid) begin
			unique case (st_q)
				HUNT: begin
					good_d = hdrBad ? 7'h00 : good_q + 7'h01;
					if (!hdrBad && good_q == LOCK_GOOD - 7'h01) begin
						st_d = LOCKED;
						lost_d = 1'b0;
						bad_d = 5'h00;
						win_d = 6'h00;
						words_d = 16'h0000;
						miss_d = 1'b0;
					end
				end
				LOCKED: begin
					win_d = win_q + 6'h01;
					bad_d = (win_q == BAD_WINDOW) ? 5'h00 : bad_q + {4'h0, hdrBad};
					// Markers count only where expected once first found.
					if (isMarker && (!seen_q || words_q == spacing)) begin
						seen_d = 1'b1;
						words_d = 16'h0000;
					end else if (words_q != 16'hFFFF) begin
						words_d = words_q + 16'h0001;
					end
					if (!seen_q && words_q == spacing)
						miss_d = 1'b1;
					if (hdrBad && bad_q == LOSE_BAD - 5'h01) begin
						st_d = HUNT;
						lost_d = 1'b1;
						seen_d = 1'b0;
						good_d = 7'h00;
					end
				end
			endcase
			// Increment emitted every eight blocks, at most eight.
			grp_d = grp_q + 3'h1;
			acc_d = acc_q + {3'h0, hdrBad};
			if (grp_q == ERR_GROUP_LAST) begin
				errCnt_d = acc_q + {3'h0, hdrBad};
				errValid_d = 1'b1;
				acc_d = 4'h0;
			end
		end
		synced_d = (st_d == LOCKED) && seen_d;
		syncedErr_d = lost_d || miss_d;
	end

	// State registers, frozen while the clock enable is low.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= HUNT;
			good_q <= 7'h00;
			bad_q <= 5'h00;
			win_q <= 6'h00;
			words_q <= 16'h0000;
			seen_q <= 1'b0;
			lost_q <= 1'b0;
			miss_q <= 1'b0;
			grp_q <= 3'h0;
			acc_q <= 4'h0;
			errCnt_q <= 4'h0;
			errValid_q <= 1'b0;
			synced_q <= 1'b0;
			syncedErr_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			good_q <= good_d;
			bad_q <= bad_d;
			win_q <= win_d;
			words_q <= words_d;
			seen_q <= seen_d;
			lost_q <= lost_d;
			miss_q <= miss_d;
			grp_q <= grp_d;
			acc_q <= acc_d;
			errCnt_q <= errCnt_d;
			errValid_q <= errValid_d;
			synced_q <= synced_d;
			syncedErr_q <= syncedErr_d;
		end
	end
endmodule

// [rtl/rx_check_pkg.sv]
// Constants shared by the receive frame checker and lane status logic.
package rx_check_pkg;
	// ==========================================================
	// Geometry.
	localparam int LANE_COUNT = 4;
	localparam int BYTES_PER_WORD = 8;
	localparam int BUF_DEPTH = 16;
	localparam int IRQ_W = 5;
	// ==========================================================
	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAX_LEN = 8'h04;
	localparam logic [7:0] OFS_MIN_LEN = 8'h08;
	localparam logic [7:0] OFS_SPACING = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
	localparam logic [7:0] OFS_LANE_STATUS = 8'h1C;
	localparam logic [7:0] OFS_MARKER_BASE = 8'h40;
	// ==========================================================
	// Field positions.
	localparam int CTRL_FCS_BYPASS = 0;
	localparam int IRQ_FCS = 0;
	localparam int IRQ_OVER = 1;
	localparam int IRQ_UNDER = 2;
	localparam int IRQ_RUNT = 3;
	localparam int IRQ_LOCK = 4;
	localparam int LS_ERR_POS = 4;
	localparam int LS_FAULT_POS = 8;
	// ==========================================================
	// Reset values and counts.
	localparam logic [14:0] MAX_LEN_RST = 15'h05EE;
	localparam logic [7:0] MIN_LEN_RST = 8'h40;
	localparam logic [15:0] SPACING_RST = 16'h3FFF;
	localparam logic [15:0] RUNT_BYTES = 16'h0040;
	localparam logic [6:0] LOCK_GOOD = 7'h40;
	localparam logic [4:0] LOSE_BAD = 5'h10;
	localparam logic [5:0] BAD_WINDOW = 6'h3F;
	localparam logic [2:0] ERR_GROUP_LAST = 3'h7;
endpackage

// [rtl/rx_frame_check_lane_sync_status.sv]
// Receive frame length and FCS checking, runt drop, lane status and register slave.
module rx_frame_check_lane_sync_status import rx_check_pkg::*; #(
	parameter int LANES = LANE_COUNT,
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq,
	// Decoded receive stream in.
	input wire logic inValid,
	input wire logic [63:0] inData,
	input wire logic inSop,
	input wire logic inEop,
	input wire logic [2:0] inEmpty,
	input wire logic inFcsBad,
	// Receive stream to user logic.
	output logic outEna,
	output logic [63:0] outData,
	output logic outSop,
	output logic outEop,
	output logic [2:0] outEmpty,
	output logic outErr,
	output logic fcsBadStat,
	// Lane blocks in.
	input wire logic [LANES-1:0] laneBlkValid,
	input wire logic [LANES-1:0] laneHdrBad,
	input wire logic [LANES-1:0][63:0] laneBlk,
	input wire logic rxLocalFaultPin,
	// Lane status out.
	output logic [LANES-1:0] synced,
	output logic [LANES-1:0] syncedErr,
	output logic [LANES-1:0][3:0] framingErr,
	output logic [LANES-1:0] framingErrValid,
	output logic localFault
);
	localparam int AW = $clog2(DEPTH);

	// Merges a byte-enabled write into an old word.
	function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	// ==========================================================
	// Register file.
	logic [31:0] ctrl_q, ctrl_d, maxLen_q, maxLen_d, minLen_q, minLen_d, spacing_q, spacing_d;
	logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqEn_q, irqEn_d, events;
	logic [LANES-1:0][1:0][31:0] pat_q, pat_d;
	logic [31:0] rdData;
	logic ack_d, irq_d, wrHit;
	logic [LANES-1:0] laneSynced, laneErr, laneErrValid;
	logic [LANES-1:0][3:0] laneCnt;
	logic [LANES-1:0] syncedPrev_q;
	logic fault_d, faultSync;

	// A write lands at the edge where the master samples ack high, never earlier.
	// Read data is registered at the same edge as ack so that it stands together with ack.
	assign wrHit = cyc_i && stb_i && we_i && ack_o;

	// Register decode, read mux and sticky status with set winning over clear.
	always_comb begin
		ctrl_d = ctrl_q;
		maxLen_d = maxLen_q;
		minLen_d = minLen_q;
		spacing_d = spacing_q;
		irqEn_d = irqEn_q;
		pat_d = pat_q;
		irqStat_d = irqStat_q;
		rdData = 32'h0000_0000;
		if (wrHit && adr_i == OFS_IRQ_CLEAR)
			irqStat_d = irqStat_q & ~dat_i[IRQ_W-1:0];
		irqStat_d = irqStat_d | events;
		if (wrHit) begin
			unique case (adr_i)
				OFS_CTRL: ctrl_d = wmask(ctrl_q, dat_i, sel_i) & 32'h0000_0001;
				OFS_MAX_LEN: maxLen_d = wmask(maxLen_q, dat_i, sel_i) & 32'h0000_7FFF;
				OFS_MIN_LEN: minLen_d = wmask(minLen_q, dat_i, sel_i) & 32'h0000_00FF;
				OFS_SPACING: spacing_d = wmask(spacing_q, dat_i, sel_i) & 32'h0000_FFFF;
				OFS_IRQ_ENABLE: irqEn_d = IRQ_W'(wmask({{(32-IRQ_W){1'b0}}, irqEn_q}, dat_i, sel_i) & 32'h0000_001F);
				default: ;
			endcase
		end
		for (int l = 0; l < LANES; l++)
			for (int h = 0; h < 2; h++)
				if (wrHit && adr_i == OFS_MARKER_BASE + 8'(8 * l + 4 * h))
					pat_d[l][h] = wmask(pat_q[l][h], dat_i, sel_i);
		unique case (adr_i)
			OFS_CTRL: rdData = ctrl_q;
			OFS_MAX_LEN: rdData = maxLen_q;
			OFS_MIN_LEN: rdData = minLen_q;
			OFS_SPACING: rdData = spacing_q;
			OFS_IRQ_STATUS: rdData = {{(32-IRQ_W){1'b0}}, irqStat_q};
			OFS_IRQ_ENABLE: rdData = {{(32-IRQ_W){1'b0}}, irqEn_q};
			OFS_LANE_STATUS: rdData = 32'({localFault, syncedErr, synced});
			default: ;
		endcase
		for (int l = 0; l < LANES; l++)
			for (int h = 0; h < 2; h++)
				if (adr_i == OFS_MARKER_BASE + 8'(8 * l + 4 * h))
					rdData = pat_q[l][h];
		ack_d = cyc_i && stb_i && !ack_o;
		irq_d = |(irqStat_q & irqEn_q);
	end

	// ==========================================================
	// Frame checking and runt holding buffer.
	logic [63:0] memData [DEPTH];
	logic [5:0] memCtl [DEPTH];
	logic [AW-1:0] wr_q, wr_d, start_q, start_d, commit_q, commit_d, rd_q, rd_d;
	logic [15:0] len_q, len_d, base, wordBytes, lenNext, lenEff, keep;
	logic drop_q, drop_d, accept, over, eopEff, errEff, runt;
	logic [2:0] emptyEff;
	logic outEna_d, fcsBad_d;

	// Per-word length tracking, truncation, error marking and runt discard.
	always_comb begin
		base = inSop ? 16'h0000 : len_q;
		wordBytes = 16'(BYTES_PER_WORD) - {13'h0000, inEmpty};
		lenNext = base + wordBytes;
		// A word that fills the limit exactly while more follows is the cut point, so no extra word leaks.
		over = (lenNext > {1'b0, maxLen_q[14:0]}) || (lenNext == {1'b0, maxLen_q[14:0]} && !inEop);
		keep = {1'b0, maxLen_q[14:0]} - base;
		emptyEff = over ? 3'(16'(BYTES_PER_WORD) - keep) : inEmpty;
		lenEff = over ? {1'b0, maxLen_q[14:0]} : lenNext;
		eopEff = inEop || over;
		accept = inValid && !(drop_q && !inSop);
		errEff = over || (eopEff && lenEff < {8'h00, minLen_q[7:0]})
			|| (inEop && inFcsBad && !ctrl_q[CTRL_FCS_BYPASS]);
		runt = eopEff && lenEff < RUNT_BYTES;
		start_d = (accept && inSop) ? wr_q : start_q;
		wr_d = wr_q;
		commit_d = commit_q;
		len_d = len_q;
		drop_d = drop_q;
		events = '0;
		if (accept) begin
			len_d = lenEff;
			drop_d = over && !inEop;
			wr_d = runt ? start_d : wr_q + AW'(1);
			if (lenEff >= RUNT_BYTES)
				commit_d = wr_q + AW'(1);
			events[IRQ_FCS] = inEop && inFcsBad;
			events[IRQ_OVER] = over;
			events[IRQ_UNDER] = eopEff && !runt && lenEff < {8'h00, minLen_q[7:0]};
			events[IRQ_RUNT] = runt;
		end else if (inValid && inEop) begin
			drop_d = 1'b0;
		end
		events[IRQ_LOCK] = |(syncedPrev_q & ~laneSynced);
		fcsBad_d = accept && inEop && inFcsBad;
		outEna_d = rd_q != commit_q;
		rd_d = outEna_d ? rd_q + AW'(1) : rd_q;
		fault_d = !(&laneSynced) || faultSync;
	end

	// Buffer writes; read word is registered straight to the stream outputs.
	always_ff @(posedge ref_clk) begin
		if (ce && accept)
			memData[wr_q] <= inData;
		if (ce && accept)
			memCtl[wr_q] <= {inSop, eopEff, emptyEff, errEff && eopEff};
	end

	// ==========================================================
	// Lane monitors and fault synchroniser.
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		lane_monitor u_lane (
			.clk(ref_clk),
			.rst_n(rst_n),
			.ce(ce),
			.blkValid(laneBlkValid[l]),
			.hdrBad(laneHdrBad[l]),
			.blk(laneBlk[l]),
			.lanePattern({pat_q[l][1], pat_q[l][0]}),
			.spacing(spacing_q[15:0]),
			.synced_q(laneSynced[l]),
			.syncedErr_q(laneErr[l]),
			.errCnt_q(laneCnt[l]),
			.errValid_q(laneErrValid[l])
		);
	end

	bit_sync u_fault_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.din(rxLocalFaultPin),
		.dout(faultSync)
	);

	// State registers other than the buffer words; nothing moves while the clock enable is low.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_q <= 32'h0000_0000;
			maxLen_q <= {17'h00000, MAX_LEN_RST};
			minLen_q <= {24'h000000, MIN_LEN_RST};
			spacing_q <= {16'h0000, SPACING_RST};
			irqStat_q <= '0;
			irqEn_q <= '0;
			pat_q <= '0;
			dat_o <= 32'h0000_0000;
			ack_o <= 1'b0;
			irq <= 1'b0;
			wr_q <= '0;
			start_q <= '0;
			commit_q <= '0;
			rd_q <= '0;
			len_q <= 16'h0000;
			drop_q <= 1'b0;
			outEna <= 1'b0;
			outData <= 64'h0000_0000_0000_0000;
			{outSop, outEop, outEmpty, outErr} <= 6'h00;
			fcsBadStat <= 1'b0;
			synced <= '0;
			syncedErr <= '0;
			framingErr <= '0;
			framingErrValid <= '0;
			syncedPrev_q <= '0;
			localFault <= 1'b0;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			maxLen_q <= maxLen_d;
			minLen_q <= minLen_d;
			spacing_q <= spacing_d;
			irqStat_q <= irqStat_d;
			irqEn_q <= irqEn_d;
			pat_q <= pat_d;
			dat_o <= rdData;
			ack_o <= ack_d;
			irq <= irq_d;
			wr_q <= wr_d;
			start_q <= start_d;
			commit_q <= commit_d;
			rd_q <= rd_d;
			len_q <= len_d;
			drop_q <= drop_d;
			outEna <= outEna_d;
			outData <= memData[rd_q];
			{outSop, outEop, outEmpty, outErr} <= outEna_d ? memCtl[rd_q] : 6'h00;
			fcsBadStat <= fcsBad_d;
			synced <= laneSynced;
			syncedErr <= laneErr;
			framingErr <= laneCnt;
			framingErrValid <= laneErrValid;
			syncedPrev_q <= laneSynced;
			localFault <= fault_d;
		end
	end
endmodule

// [verif/rx_check_chk.sv]
// Assertion checker that watches the ports of the receive frame checker.
module rx_check_chk import rx_check_pkg::*; #(
	parameter int LANES = LANE_COUNT
) (
	// Clock and control.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register bus.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic ack_o,
	// Frame stream.
	input wire logic inValid,
	input wire logic inEop,
	input wire logic inFcsBad,
	input wire logic outEna,
	input wire logic outSop,
	input wire logic outEop,
	input wire logic outErr,
	input wire logic fcsBadStat,
	// Lane status.
	input wire logic rxLocalFaultPin,
	input wire logic [LANES-1:0] synced,
	input wire logic [LANES-1:0] framingErrValid,
	input wire logic localFault
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Frame tracker
	logic open_q;
	logic open_d;
	// Goes high after a delivered start and low after its end.
	always_comb begin
		open_d = open_q;
		if (outEna && ce) begin
			open_d = !outEop;
		end
	end
	// Registers the tracker, cleared by reset.
	always_ff @(posedge ref_clk) begin
		open_q <= rst_n ? open_d : 1'b0;
	end
	// ==========================================================
	// Properties
	sequence s_req;
		cyc_i && stb_i && !ack_o && ce;
	endsequence
	sequence s_pin_held;
		(rxLocalFaultPin && ce) [*4];
	endsequence
	a_ack_answer: assert property (s_req |=> ack_o)
		else $error("bus request left without ack");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_err_at_end: assert property (outErr |-> outEna && outEop)
		else $error("error flag away from the last transfer");
	a_ctl_idle: assert property (!outEna |-> !outSop && !outEop && !outErr)
		else $error("stream flags without transfer enable");
	a_frame_whole: assert property (outEna && !open_q |-> outSop)
		else $error("frame delivered without its start");
	a_fcs_status: assert property (inValid && inEop && inFcsBad && ce |-> ##[1:20] fcsBadStat)
		else $error("bad frame check status not reported");
	a_err_valid: assert property (framingErrValid[0] |=> !framingErrValid[0])
		else $error("error count valid held two cycles");
	a_fault_pin: assert property (s_pin_held |-> localFault)
		else $error("received fault not shown as local fault");
	a_sync_fault: assert property (!(&synced) [*3] |-> localFault)
		else $error("unsynced lane not shown as local fault");
endmodule

bind rx_frame_check_lane_sync_status rx_check_chk #(.LANES(LANES)) u_rx_check_chk (.ref_clk(ref_clk),
	.rst_n(rst_n), .ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .inValid(inValid), .inEop(inEop),
	.inFcsBad(inFcsBad), .outEna(outEna), .outSop(outSop), .outEop(outEop), .outErr(outErr),
	.fcsBadStat(fcsBadStat), .rxLocalFaultPin(rxLocalFaultPin), .synced(synced),
	.framingErrValid(framingErrValid), .localFault(localFault));

// [verif/rx_user_sink.sv]
// Model of the user logic that takes the checked frame stream.
module rx_user_sink (
	// Clock.
	input wire logic ref_clk,
	// Stream from the checker.
	input wire logic outEna,
	input wire logic outEop,
	input wire logic [2:0] outEmpty,
	input wire logic outErr,
	input wire logic [63:0] outData,
	// Count of finished frames and totals of the last finished frame.
	output int frames,
	output int lastLen,
	output logic lastErr,
	output logic [63:0] lastData
);
	timeunit 1ns;
	timeprecision 1ns;
	int run = 0;
	initial frames = 0;
	// Counts the bytes of each frame and keeps them once it ends.
	always @(posedge ref_clk) begin
		if (outEna === 1'b1) begin
			run = run + 8;
			if (outEop === 1'b1) begin
				lastLen <= run - int'(outEmpty);
				lastErr <= outErr;
				lastData <= outData;
				frames <= frames + 1;
				run = 0;
			end
		end
	end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the receive frame checker and lane status.
module tb_top import rx_check_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, ce = 1, cyc = 0, stb = 0, we = 0, pin = 0;
	logic [63:0] lastData;
	logic inValid = 0, inSop = 0, inEop = 0, inFcsBad = 0;
	logic [7:0] adr = 0;
	logic [31:0] wdat = 0, rdat, r;
	logic [63:0] inData = 0, outData;
	logic [2:0] inEmpty = 0, outEmpty;
	logic [3:0] laneValid = 0, laneBad = 0, synced, syncedErr, errValid;
	logic [3:0][63:0] laneBlk = '0;
	logic [3:0][3:0] errCnt;
	logic ack, irq, outEna, outSop, outEop, outErr, fcsStat, localFault, lastErr;
	int err_total = 0, compares = 0, fcsSeen = 0, frames, lastLen, f, c;
	int errSum [4] = '{0, 0, 0, 0};
	typedef struct {int len; logic bad; logic byp; int maxL; int minL; int expLen; logic expErr;} row_s;
	// Frame cases: length, bad check, bypass, limits, delivered length, error.
	row_s rows [9] = '{'{64, 0, 0, 1518, 64, 64, 0}, '{100, 1, 0, 1518, 64, 100, 1},
		'{100, 1, 1, 1518, 64, 100, 0}, '{63, 0, 0, 1518, 64, 0, 0}, '{56, 1, 1, 1518, 64, 0, 0},
		'{200, 0, 0, 150, 64, 150, 1}, '{150, 0, 0, 150, 64, 150, 0}, '{72, 0, 0, 1518, 100, 72, 1},
		'{72, 0, 0, 1518, 72, 72, 0}};
	logic [7:0] regA [6] = '{OFS_CTRL, OFS_MAX_LEN, OFS_MIN_LEN, OFS_SPACING, OFS_IRQ_ENABLE, 8'h30};
	logic [31:0] regV [6] = '{32'h0, 32'(MAX_LEN_RST), 32'(MIN_LEN_RST), 32'h3FFF, 32'h0, 32'h0};

	always #25 ref_clk = ~ref_clk;

	rx_frame_check_lane_sync_status u_rx_frame_check_lane_sync_status (.ref_clk(ref_clk), .rst_n(rst_n),
		.ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat),
		.ack_o(ack), .irq(irq), .inValid(inValid), .inData(inData), .inSop(inSop), .inEop(inEop),
		.inEmpty(inEmpty), .inFcsBad(inFcsBad), .outEna(outEna), .outData(outData), .outSop(outSop),
		.outEop(outEop), .outEmpty(outEmpty), .outErr(outErr), .fcsBadStat(fcsStat),
		.laneBlkValid(laneValid), .laneHdrBad(laneBad), .laneBlk(laneBlk), .rxLocalFaultPin(pin),
		.synced(synced), .syncedErr(syncedErr), .framingErr(errCnt), .framingErrValid(errValid),
		.localFault(localFault));
	rx_user_sink u_rx_user_sink (.ref_clk(ref_clk), .outEna(outEna), .outEop(outEop), .outEmpty(outEmpty),
		.outErr(outErr), .outData(outData), .frames(frames), .lastLen(lastLen), .lastErr(lastErr),
		.lastData(lastData));

	// Tallies status pulses and lane error increments seen while valid.
	always @(posedge ref_clk) begin
		fcsSeen <= fcsSeen + int'(fcsStat === 1'b1);
		for (int l = 0; l < 4; l++) begin
			if (errValid[l] === 1'b1) begin
				errSum[l] <= errSum[l] + int'(errCnt[l]);
			end
		end
	end

	// ==========================================================
	// Tasks
	task automatic summarize();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One classic bus cycle, held until ack is sampled high.
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		int n = 0;
		@(posedge ref_clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		r = rdat;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (ack !== 1'b1) begin
			err_total++;
			summarize();
		end
	endtask
	// Sends one frame at full rate; only the last word may be partly empty.
	task automatic send(int len, logic bad);
		int w = (len + 7) / 8;
		for (int i = 0; i < w; i++) begin
			@(posedge ref_clk);
			inValid <= 1;
			inData <= {8{8'(i)}};
			inSop <= (i == 0);
			inEop <= (i == w - 1);
			inEmpty <= (i == w - 1) ? 3'(w * 8 - len) : 3'h0;
			inFcsBad <= bad;
		end
		@(posedge ref_clk);
		inValid <= 0;
		inEop <= 0;
	endtask
	// Sends n blocks on every lane, then lets status settle.
	task automatic lanes(int n, logic bad, logic mark);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			laneValid <= 4'hF;
			laneBad <= {4{bad}};
			for (int l = 0; l < 4; l++) begin
				laneBlk[l] <= mark ? {32'h5A5A5A5A, 32'hC0DE0000 + 32'(l)} : 64'h1111;
			end
		end
		@(posedge ref_clk);
		laneValid <= 4'h0;
		repeat (4) @(posedge ref_clk);
	endtask

	// Cuts a hung run short.
	initial begin
		repeat (60000) @(posedge ref_clk);
		err_total++;
		summarize();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1;
		foreach (regA[k]) begin
			wb(0, regA[k], 0);
			check("reset value", r, regV[k]);
		end
		$display("test reset values done");
		foreach (rows[k]) begin
			wb(1, OFS_CTRL, 32'(rows[k].byp));
			wb(1, OFS_MAX_LEN, 32'(rows[k].maxL));
			wb(1, OFS_MIN_LEN, 32'(rows[k].minL));
			f = frames;
			c = fcsSeen;
			send(rows[k].len, rows[k].bad);
			repeat (40) @(posedge ref_clk);
			check("frames", frames - f, 32'(rows[k].expLen != 0));
			if (rows[k].expLen != 0) begin
				check("length", lastLen, rows[k].expLen);
				check("error", lastErr, rows[k].expErr);
				check("last data", lastData[31:0], {4{8'((rows[k].expLen + 7) / 8 - 1)}});
			end
			check("fcs status", fcsSeen - c, 32'(rows[k].bad));
			$display("test row %0d done", k);
		end
		// The four frame event bits (FCS, over, under, runt) are set by now, lock is not; irq stays off the line while masked.
		wb(0, OFS_IRQ_STATUS, 0);
		check("irq status", r[3:0], 4'hF);
		check("irq masked", irq, 0);
		wb(1, OFS_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge ref_clk);
		check("irq raised", irq, 1);
		wb(1, OFS_IRQ_CLEAR, 32'h1F);
		wb(1, OFS_IRQ_STATUS, 32'h1F);
		repeat (2) @(posedge ref_clk);
		check("irq cleared", irq, 0);
		wb(0, OFS_IRQ_STATUS, 0);
		check("irq status clear", r[3:0], 4'h0);
		$display("test irq done");
		// Lanes are idle while their patterns load.
		for (int l = 0; l < 4; l++) begin
			wb(1, OFS_MARKER_BASE + 8'(8 * l), 32'hC0DE0000 + 32'(l));
			wb(1, OFS_MARKER_BASE + 8'(8 * l + 4), 32'h5A5A5A5A);
		end
		lanes(71, 0, 0);
		check("synced before marker", synced, 4'h0);
		lanes(1, 0, 1);
		lanes(8, 0, 0);
		check("synced", synced, 4'hF);
		check("lock error", syncedErr, 4'h0);
		check("fault off", localFault, 0);
		// With the clock enable low the raised fault pin must not get through.
		ce <= 0;
		pin <= 1;
		repeat (6) @(posedge ref_clk);
		check("fault frozen", localFault, 0);
		ce <= 1;
		repeat (6) @(posedge ref_clk);
		check("fault from pin", localFault, 1);
		pin <= 0;
		lanes(16, 1, 0);
		lanes(8, 0, 0);
		check("lock lost", syncedErr, 4'hF);
		check("synced lost", synced, 4'h0);
		for (int l = 0; l < 4; l++) begin
			check("header errors", errSum[l], 16);
		end
		$display("test lanes done");
		rst_n <= 0;
		repeat (2) @(posedge ref_clk);
		check("reset lock error", syncedErr, 4'h0);
		check("reset enable", outEna, 0);
		rst_n <= 1;
		wb(0, OFS_MAX_LEN, 0);
		check("max after reset", r, 32'(MAX_LEN_RST));
		// A short spacing with no marker ever seen must raise the lock error.
		wb(1, OFS_SPACING, 32'h7);
		lanes(80, 0, 0);
		check("marker missing", syncedErr, 4'hF);
		check("synced no marker", synced, 4'h0);
		$display("test second reset done");
		summarize();
	end
endmodule
